// ==== hw/cfww_defs.vh ====
// Constants for the configuration word and watchdog block
`ifndef CFWW_DEFS_VH
`define CFWW_DEFS_VH
// APB register byte offsets
`define CFWW_OFS_CFG      12'h000
`define CFWW_OFS_CTRL     12'h004
`define CFWW_OFS_CLEAR    12'h008
`define CFWW_OFS_STATUS   12'h00c
`define CFWW_OFS_COUNT    12'h010
// Configuration word field positions
`define CFWW_CFG_CP       28
`define CFWW_CFG_BWL      24
`define CFWW_CFG_PWP_HI   19
`define CFWW_CFG_PWP_LO   12
`define CFWW_CFG_DCS      3
`define CFWW_CFG_DBG_HI   1
`define CFWW_CFG_DBG_LO   0
// Reserved bits: mask and forced value
`define CFWW_CFG_RSV_MASK 32'hee_f0_0f_f4
`define CFWW_CFG_RSV_VAL  32'h6e_f0_0f_f4
// Control register fields
`define CFWW_CTRL_ON      0
`define CFWW_CTRL_PS_LO   1
`define CFWW_CTRL_PS_HI   4
// Clear key value
`define CFWW_CLR_KEY      32'h0000_5743
// Low-power oscillator tick period in ns, and system clock period in ns
`define CFWW_LOW_POWER_RC_CLOCK_NS      32000
`define CFWW_CLK_NS       100
`endif

// ==== hw/cfww_tick.v ====
// Tick divider that stands in for the low-power oscillator
`timescale 1ns/1ps
module cfww_tick #(
  parameter DIV = 320
) (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_n_i,
  // One-cycle tick out
  output reg  tick_o
);
  reg [15:0] cnt_reg; // Divider count

  // Free-running divider; runs regardless of watchdog state
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b0;
    end
    else if (cnt_reg == DIV[15:0] - 16'h0001)
    begin
      cnt_reg <= 16'h0000;
      tick_o  <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
      tick_o  <= 1'b0;
    end
  end
endmodule // cfww_tick

// ==== hw/cfww_top.v ====
// Configuration word and watchdog timer with APB registers
// How it works
// - Code-protect zero blocks external flash access
// - Boot-lock zero blocks boot writes while running
// - Watchdog counts low-power clock ticks only
// - Timeout without clear resets the device
// - Postscaler selects among several timeout periods
// - Timeout during sleep wakes device
// - Enable from configuration or software control
`timescale 1ns/1ps
`include "cfww_defs.vh"
module cfww_top #(
  parameter TICK_DIV = `CFWW_LOW_POWER_RC_CLOCK_NS / `CFWW_CLK_NS, // Clocks per slow tick
  parameter BASE_TICKS = 32                          // Slow ticks per postscale unit
) (
  // Clock and reset
  input  wire        CLK_I,
  input  wire        RESETN_I,
  // APB slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  // Programmed configuration word, loaded once after reset
  input  wire [31:0] CFG_WORD_I,
  input  wire        CFG_WDT_EN_I,
  // Power state and access requests
  input  wire        SLEEP_I,
  input  wire        PROG_ACCESS_I,
  input  wire        BOOT_WRITE_I,
  // Results
  output reg         PROG_ACCESS_OK_O,
  output reg         BOOT_WRITE_OK_O,
  output reg         WDT_RESET_O,
  output reg         WAKE_O
);
  reg        rst_s1_reg;   // Reset synchroniser stage 1
  reg        rst_n;        // Synchronised reset
  reg [31:0] cfg_reg;      // Captured configuration word
  reg        cfg_en_reg;   // Captured configuration enable
  reg        loaded_reg;   // Capture done
  reg        sw_on_reg;    // Software enable
  reg [3:0]  ps_reg;       // Postscaler select
  reg [15:0] base_reg;     // Ticks within one base unit
  reg [15:0] post_reg;     // Base units elapsed
  reg        tout_reg;     // Timeout seen, sticky until clear or disable
  wire       tick;         // Slow tick pulse
  wire       wdt_on;       // Effective enable
  wire       acc;          // APB access phase
  wire       clr_hit;      // Valid clear write
  wire [31:0] cfg_eff;     // Word with reserved bits forced

  // Divider turning the main clock into the low-power tick
  cfww_tick #(.DIV(TICK_DIV)) u_tick (
    .clk_i   (CLK_I),
    .rst_n_i (rst_n),
    .tick_o  (tick)
  );

  // Postscaler limit: 2^ps base units
  function [15:0] ps_limit;
    input [3:0] sel;
    begin
      ps_limit = 16'h0001 << sel;
    end
  endfunction

  // Reset release through two flops
  always @(posedge CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  // Reserved bits read as their fixed values regardless of programming
  assign cfg_eff = (cfg_reg & ~`CFWW_CFG_RSV_MASK) | `CFWW_CFG_RSV_VAL;
  assign wdt_on  = cfg_en_reg | sw_on_reg;
  assign acc     = PSEL_I & PENABLE_I;
  assign clr_hit = acc & PWRITE_I & (PADDR_I == `CFWW_OFS_CLEAR) &
                   (PWDATA_I == `CFWW_CLR_KEY);

  // Capture of the configuration word after reset release
  always @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_reg    <= 32'h0000_0000;
      cfg_en_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end
    else if (!loaded_reg)
    begin
      cfg_reg    <= CFG_WORD_I;
      cfg_en_reg <= CFG_WDT_EN_I;
      loaded_reg <= 1'b1;
    end
  end

  // Access gates; protected until the word is loaded
  always @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PROG_ACCESS_OK_O <= 1'b0;
      BOOT_WRITE_OK_O  <= 1'b0;
    end
    else
    begin
      PROG_ACCESS_OK_O <= PROG_ACCESS_I & loaded_reg & cfg_reg[`CFWW_CFG_CP];
      BOOT_WRITE_OK_O  <= BOOT_WRITE_I & loaded_reg & cfg_reg[`CFWW_CFG_BWL];
    end
  end

  // Watchdog counter, ticked only by the slow clock
  always @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_reg    <= 16'h0000;
      post_reg    <= 16'h0000;
      tout_reg    <= 1'b0;
      WDT_RESET_O <= 1'b0;
      WAKE_O      <= 1'b0;
    end
    else
    begin
      WDT_RESET_O <= 1'b0;
      WAKE_O      <= 1'b0;
      if (!wdt_on || clr_hit)
      begin
        // Disabled or cleared: full period restarts
        base_reg <= 16'h0000;
        post_reg <= 16'h0000;
        tout_reg <= 1'b0;
      end
      else if (tick)
      begin
        if (base_reg == BASE_TICKS[15:0] - 16'h0001)
        begin
          base_reg <= 16'h0000;
          // Compare with >= so a postscale lowered mid-count still times out
          if (post_reg >= ps_limit(ps_reg) - 16'h0001)
          begin
            post_reg <= 16'h0000;
            tout_reg <= 1'b1;
            if (SLEEP_I)
              WAKE_O <= 1'b1;
            else
              WDT_RESET_O <= 1'b1;
          end
          else
            post_reg <= post_reg + 16'h0001;
        end
        else
          base_reg <= base_reg + 16'h0001;
      end
    end
  end

  // APB writes and read data; zero wait states
  always @(posedge CLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_on_reg <= 1'b0;
      ps_reg    <= 4'h0;
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= 1'b0;
      if (PSEL_I & ~PENABLE_I)
      begin
        case (PADDR_I)
          `CFWW_OFS_CFG:    PRDATA_O <= cfg_eff;
          `CFWW_OFS_CTRL:   PRDATA_O <= {27'h0, ps_reg, sw_on_reg};
          `CFWW_OFS_STATUS: PRDATA_O <= {29'h0, tout_reg, cfg_en_reg, wdt_on};
          `CFWW_OFS_COUNT:  PRDATA_O <= {post_reg, base_reg};
          `CFWW_OFS_CLEAR:  PRDATA_O <= 32'h0000_0000;
          default:
          begin
            PRDATA_O  <= 32'h0000_0000;
            PSLVERR_O <= 1'b1; // Unmapped address
          end
        endcase
      end
      if (acc & PWRITE_I & (PADDR_I == `CFWW_OFS_CTRL))
      begin
        sw_on_reg <= PWDATA_I[`CFWW_CTRL_ON];
        ps_reg    <= PWDATA_I[`CFWW_CTRL_PS_HI:`CFWW_CTRL_PS_LO];
      end
    end
  end
endmodule // cfww_top

// ==== bench/cfww_properties.sv ====
// Checker for flash gating, timeout pulses and APB answer timing
`timescale 1ns/1ps
module cfww_properties (
  input wire CLK_I,
  input wire RESETN_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PREADY_O,
  input wire SLEEP_I,
  input wire PROG_ACCESS_I,
  input wire BOOT_WRITE_I,
  input wire PROG_ACCESS_OK_O,
  input wire BOOT_WRITE_OK_O,
  input wire WDT_RESET_O,
  input wire WAKE_O,
  input wire [31:0] CFG_WORD_I
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  property p_prog;
    PROG_ACCESS_OK_O |-> $past(PROG_ACCESS_I) && $past(CFG_WORD_I[28]);
  endproperty
  a_prog: assert property (p_prog) else $error("Access granted with no request");
  property p_boot;
    BOOT_WRITE_OK_O |-> $past(BOOT_WRITE_I) && $past(CFG_WORD_I[24]);
  endproperty
  a_boot: assert property (p_boot) else $error("Boot write with no request");
  property p_wake; WAKE_O |-> $past(SLEEP_I); endproperty
  a_wake: assert property (p_wake) else $error("Wake while awake");
  property p_rst; WDT_RESET_O |-> !$past(SLEEP_I); endproperty
  a_rst: assert property (p_rst) else $error("Reset instead of wake");
  property p_both; !(WAKE_O && WDT_RESET_O); endproperty
  a_both: assert property (p_both) else $error("Reset and wake together");
  property p_gap; WDT_RESET_O || WAKE_O |=> !(WDT_RESET_O || WAKE_O) [*3]; endproperty
  a_gap: assert property (p_gap) else $error("Timeouts too close");
  property p_rdy; PSEL_I && !PENABLE_I |=> PREADY_O; endproperty
  a_rdy: assert property (p_rdy) else $error("No ready after setup");
  property p_one; PREADY_O |=> !PREADY_O; endproperty
  a_one: assert property (p_one) else $error("Ready longer than one cycle");
  c_rst: cover property (WDT_RESET_O);
  c_wake: cover property (WAKE_O);
  c_boot: cover property (BOOT_WRITE_OK_O);
endmodule // cfww_properties
bind cfww_top cfww_properties chk_u (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .SLEEP_I(SLEEP_I),
  .PROG_ACCESS_I(PROG_ACCESS_I), .BOOT_WRITE_I(BOOT_WRITE_I),
  .PROG_ACCESS_OK_O(PROG_ACCESS_OK_O), .BOOT_WRITE_OK_O(BOOT_WRITE_OK_O),
  .WDT_RESET_O(WDT_RESET_O), .WAKE_O(WAKE_O), .CFG_WORD_I(CFG_WORD_I));

// ==== bench/cfww_partner.sv ====
// Programmer and running software: config word and flash requests
`timescale 1ns/1ps
module cfww_partner (
  input  wire        clk_i,
  input  wire        cp_i,
  input  wire        bwl_i,
  output wire [31:0] word_o,
  output reg         prog_o = 1'b0,
  output reg         boot_o = 1'b0
);
  integer seed = 32'h7ede; // Fixed seed
  // Reserved bit 31 low, all other reserved bits high
  assign word_o = {3'b011, cp_i, 3'b111, bwl_i, 4'hf, 8'ha5, 8'hff, 4'b1110};
  // Random request levels, changed after each edge
  always @(posedge clk_i)
  begin
    prog_o <= $random(seed);
    boot_o <= $random(seed);
  end
endmodule // cfww_partner

// ==== bench/cfww_tb_top.sv ====
// Bench top: APB, sleep and flash requests checked against a model
`timescale 1ns/1ps
`include "cfww_defs.vh"
`define CHK(a,b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
module config_word_and_watchdog_tb_top;
  localparam TD = 4, BT = 2; // Short tick and base counts
  reg CLK_I = 0, RESETN_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  reg [11:0] PADDR_I = 0;
  reg [31:0] PWDATA_I = 0, r;
  reg cp = 1, bwl = 0, cen = 0, SLEEP_I = 0, chk = 0, e;
  wire [31:0] PRDATA_O, word;
  wire PREADY_O, PSLVERR_O, pa, bw, pok, bok, WDT_RESET_O, WAKE_O;
  integer fail_count = 0, compares = 0, cyc = 0, last = 0, per = 0;
  integer nr = 0, nw = 0, s, n, m;
  reg [1:0] q[$];
  reg [1:0] exp_gate; // Expected gate pair, popped once per compare
  always #50 CLK_I = ~CLK_I;
  cfww_partner pt_u (.clk_i(CLK_I), .cp_i(cp), .bwl_i(bwl), .word_o(word),
    .prog_o(pa), .boot_o(bw));
  cfww_top #(.TICK_DIV(TD), .BASE_TICKS(BT)) dut_u (.CLK_I(CLK_I),
    .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
    .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .CFG_WORD_I(word), .CFG_WDT_EN_I(cen), .SLEEP_I(SLEEP_I),
    .PROG_ACCESS_I(pa), .BOOT_WRITE_I(bw), .PROG_ACCESS_OK_O(pok),
    .BOOT_WRITE_OK_O(bok), .WDT_RESET_O(WDT_RESET_O), .WAKE_O(WAKE_O));
  // Model: gating one cycle late, pulse counts, timeout spacing
  always @(posedge CLK_I)
  begin
    cyc = cyc + 1;
    nr = nr + WDT_RESET_O;
    nw = nw + WAKE_O;
    if (WDT_RESET_O) begin per = cyc - last; last = cyc; end
    if (!chk) q.delete();
    else
    begin
      if (q.size()) begin exp_gate = q.pop_front(); `CHK({bok, pok}, exp_gate) end
      q.push_back({bw & bwl, pa & cp});
    end
  end
  task finish_test;
    begin
      $display("Compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // One APB transfer, waits for ready under a bound
  task apb(input w, input [11:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge CLK_I);
      PSEL_I <= 1;
      PWRITE_I <= w;
      PADDR_I <= a;
      PWDATA_I <= d;
      @(posedge CLK_I);
      PENABLE_I <= 1;
      for (i = 0; i < 20 && PREADY_O !== 1'b1; i++) @(posedge CLK_I);
      if (i == 20) begin fail_count++; finish_test; end
      else
      begin
        r = PRDATA_O;
        e = PSLVERR_O;
        PSEL_I <= 0;
        PENABLE_I <= 0;
      end
    end
  endtask
  task boot(input c, input b, input en);
    begin
      chk <= 0;
      RESETN_I <= 0;
      cp <= c;
      bwl <= b;
      cen <= en;
      repeat (3) @(posedge CLK_I);
      RESETN_I <= 1;
      repeat (6) @(posedge CLK_I);
      chk <= 1;
    end
  endtask
  initial
  begin
    boot(1, 0, 0);
    apb(0, `CFWW_OFS_CFG, 0);
    `CHK(r, word)
    apb(0, `CFWW_OFS_CTRL, 0);
    `CHK(r, 32'h0)
    apb(0, 12'h020, 0);
    `CHK({e, r}, 33'h1_0000_0000)
    for (s = 0; s < 4; s++)
    begin
      apb(1, `CFWW_OFS_CTRL, s * 2 + 1);
      apb(0, `CFWW_OFS_CTRL, 0);
      `CHK(r, s * 2 + 1)
      repeat ((BT * TD * 3) << s) @(posedge CLK_I);
      `CHK(per, (BT * TD) << s)
    end
    apb(1, `CFWW_OFS_CTRL, 3);
    apb(1, `CFWW_OFS_CLEAR, `CFWW_CLR_KEY);
    repeat (2) @(posedge CLK_I);
    n = nr;
    repeat (10) apb(1, `CFWW_OFS_CLEAR, `CFWW_CLR_KEY);
    `CHK(nr, n)
    repeat (10) apb(1, `CFWW_OFS_CLEAR, 0);
    `CHK(nr > n, 1'b1)
    apb(0, `CFWW_OFS_STATUS, 0);
    `CHK(r[2:0], 3'b101)
    SLEEP_I <= 1;
    repeat (2) @(posedge CLK_I);
    n = nr;
    m = nw;
    repeat (40) @(posedge CLK_I);
    `CHK({nr == n, nw > m}, 2'b11)
    SLEEP_I <= 0;
    boot(0, 1, 1);
    apb(0, `CFWW_OFS_STATUS, 0);
    `CHK(r[1:0], 2'b11)
    apb(0, `CFWW_OFS_CFG, 0);
    `CHK(r, word)
    n = nr;
    repeat (40) @(posedge CLK_I);
    `CHK(nr > n, 1'b1)
    finish_test;
  end
endmodule // config_word_and_watchdog_tb_top
